/* File: verilog/sbp_pkg.sv */
// Purpose: shared constants and carriers for the six-bit port block
// Assumes: 32-bit apb, one word per register
// Notes:   printed offsets are not multiples of four, so they are indices
package sbp_pkg;
  localparam int          SBP_WIDTH        = 6;
  localparam logic [7:0]  SBP_IDX_DATA     = 8'h05;
  localparam logic [7:0]  SBP_IDX_DIR      = 8'h85;
  localparam logic [11:0] SBP_ADDR_DATA    = {2'b00, SBP_IDX_DATA, 2'b00};
  localparam logic [11:0] SBP_ADDR_DIR     = {2'b00, SBP_IDX_DIR, 2'b00};
  localparam int          SBP_OD_BIT       = 4;
  localparam int          SBP_SS_BIT       = 5;
  localparam logic [5:0]  SBP_DIR_RST      = 6'h3F;
  localparam logic [5:0]  SBP_LATCH_PWR    = 6'h00;

  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] dir;
  } sbp_state_t;

  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } sbp_pins_t;
endpackage

/* File: verilog/sbp_sync.sv */
// Purpose: two-flop synchroniser for the port pin inputs
// Assumes: pins are asynchronous to pclk
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
`default_nettype none
module sbp_sync #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sbp_port.sv */
// Purpose: six-bit general-purpose port with data latch and direction register
// Assumes: apb slave, 32-bit data, zero wait states, pins synchronised here
// Notes:   presetn is the power-on or brown-out reset; other resets are separate
//
// Overview of operation
// - only bits 5..0 exist; bits 7 and 6 read zero.
// - latch undefined after power-on (this code loads SBP_LATCH_PWR, 6'h00); kept unchanged on other resets.
// - bit 4 is open drain, pulls low only, schmitt input.
// - bit 4 pin also feeds the timer0 external clock input.
// - bit 5 pin also feeds the serial port slave select.
// - reduced build omits bit 5 of data and direction, reading zero.
// - master clear and watchdog apply other-reset values.
// - master clear is active low; device stays in reset while low.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module sbp_port #(
  parameter bit REDUCED = 1'b0
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                master_clear_n,
  input  wire logic                watchdog_reset,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [5:0]          pin_i,
  output sbp_pkg::sbp_pins_t       pins,
  output logic                     timer0_external_clock_in,
  output logic                     ssp_slave_select_n,
  output logic                     in_reset
);
  import sbp_pkg::*;

  sbp_state_t  st_r;
  sbp_state_t  st_nxt;
  logic [5:0]  pin_s;
  logic [1:0]  master_clear_n_sync_r;
  logic        wd_r;
  logic        other_rst;
  logic        acc;
  logic        hit_data;
  logic        hit_dir;
  logic [5:0]  impl;
  logic [31:0] rdata_nxt;

  // unused bit 5 is forced out of the design in the reduced build
  assign impl = REDUCED ? 6'h1F : 6'h3F;

  sbp_sync #(.W(SBP_WIDTH)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_i),
    .q       (pin_s)
  );

  // master clear arrives from a pin, so it is synchronised first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_clear_n_sync_r <= 2'b00;
      wd_r        <= 1'b0;
    end else begin
      master_clear_n_sync_r <= {master_clear_n_sync_r[0], master_clear_n};
      wd_r        <= watchdog_reset;
    end
  end

  assign other_rst = !master_clear_n_sync_r[1] || wd_r;
  assign in_reset  = other_rst;

  assign acc      = psel && penable && !other_rst;
  assign hit_data = paddr == SBP_ADDR_DATA;
  assign hit_dir  = paddr == SBP_ADDR_DIR;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_data || hit_dir);

  always_comb begin
    st_nxt = st_r;
    if (other_rst) begin
      st_nxt.dir = SBP_DIR_RST & impl;
    end else if (acc && pwrite && pstrb[0]) begin
      if (hit_data) begin
        st_nxt.latch = pwdata[5:0] & impl;
      end
      if (hit_dir) begin
        st_nxt.dir = pwdata[5:0] & impl;
      end
    end
  end

  // latch keeps its value on other resets; power-on value is a don't-care
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{latch: SBP_LATCH_PWR, dir: SBP_DIR_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (hit_data) begin
        rdata_nxt = {26'h0, pin_s & impl};
      end else if (hit_dir) begin
        rdata_nxt = {26'h0, st_r.dir & impl};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rdata_nxt;
    end
  end

  always_comb begin
    pins.o  = st_r.latch;
    pins.oe = ~st_r.dir & impl;
    pins.o[SBP_OD_BIT]  = 1'b0;
    pins.oe[SBP_OD_BIT] = !st_r.dir[SBP_OD_BIT] && !st_r.latch[SBP_OD_BIT];
  end

  // both alternate inputs see the synchronised pin (slave select is tied high in the reduced build), so the consumers get a clean level
  // at the cost of two cycles of latency
  assign timer0_external_clock_in = pin_s[SBP_OD_BIT];
  assign ssp_slave_select_n       = REDUCED ? 1'b1 : pin_s[SBP_SS_BIT];

  // extra guards on bus answers, drive enables and reset handling
  a_ready_always: assert property (@(posedge pclk) disable iff (!presetn)
    pready == 1'b1)
    else $error("ready not high");
  a_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && pstrb[0] && hit_dir) |=> st_r.dir == ($past(pwdata[5:0]) & impl))
    else $error("direction write lost");
  a_read_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && hit_dir) |=> prdata == {26'h0, $past(st_r.dir) & impl})
    else $error("direction read wrong");
  a_dir_unimpl: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r.dir & ~impl) == 6'h00)
    else $error("unimplemented direction bit set");
  a_input_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (pins.oe & st_r.dir) == 6'h00)
    else $error("input pin driven");
  a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.latch[SBP_OD_BIT] |-> !pins.oe[SBP_OD_BIT])
    else $error("open drain bit not released");
  a_ss_route: assert property (@(posedge pclk) disable iff (!presetn)
    !REDUCED |-> ssp_slave_select_n == pin_s[SBP_SS_BIT])
    else $error("slave select not routed");
  a_wd_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wd_r |-> in_reset)
    else $error("watchdog not applied as reset");
  a_master_clear_n_release: assert property (@(posedge pclk) disable iff (!presetn)
    (master_clear_n_sync_r[1] && !wd_r) |-> !in_reset)
    else $error("reset held after release");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !hit_data && !hit_dir) |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && hit_data) |-> !pslverr)
    else $error("mapped access refused");
  a_reduced_read: assert property (@(posedge pclk) disable iff (!presetn)
    REDUCED |-> !prdata[5])
    else $error("bit 5 reads one in reduced build");

  a_dir_reset_ones: assert property (@(posedge pclk) disable iff (!presetn)
    other_rst |=> st_r.dir == (SBP_DIR_RST & impl))
    else $error("direction not all ones after reset");
  a_latch_kept: assert property (@(posedge pclk) disable iff (!presetn)
    other_rst |=> st_r.latch == $past(st_r.latch))
    else $error("latch changed during other reset");
  a_latch_write: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && pstrb[0] && hit_data) |=> st_r.latch == ($past(pwdata[5:0]) & impl))
    else $error("latch write lost");
  a_read_pins: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !pwrite && hit_data) |=> prdata == {26'h0, $past(pin_s) & impl})
    else $error("data read not pin levels");
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:6] == 26'h0)
    else $error("upper bits not zero");
  a_od_no_high: assert property (@(posedge pclk) disable iff (!presetn)
    pins.oe[SBP_OD_BIT] |-> (pins.o[SBP_OD_BIT] == 1'b0 && !st_r.latch[SBP_OD_BIT]))
    else $error("open drain bit drives high");
  a_drive_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (pins.oe[3:0] == ~st_r.dir[3:0]) && (pins.o[3:0] == st_r.latch[3:0]))
    else $error("pin drive mismatches direction");
  a_reduced_zero: assert property (@(posedge pclk) disable iff (!presetn)
    REDUCED |-> (!st_r.dir[5] && !pins.oe[5]))
    else $error("bit 5 present in reduced build");
  a_t0_route: assert property (@(posedge pclk) disable iff (!presetn)
    timer0_external_clock_in == pin_s[SBP_OD_BIT])
    else $error("timer0 clock not routed");
  a_master_clear_n_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!master_clear_n [*3]) |-> in_reset)
    else $error("not in reset while master clear low");
endmodule
`default_nettype wire

/* File: verification/sbp_ext_model.sv */
// Purpose: external circuitry on the six port pins
// Assumes: released pins follow the level the bench applies
// Notes:   device drive wins over the outside level
`timescale 1ns/100ps
`default_nettype none
module sbp_ext_model
  import sbp_pkg::*;
(
  input  wire logic [5:0]         ext_level,
  input  wire sbp_pkg::sbp_pins_t pins,
  output logic      [5:0]         pin_level
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_level[i] = pins.oe[i] ? pins.o[i] : ext_level[i];
    end
  end
endmodule
`default_nettype wire

/* File: verification/sbp_port_tb.sv */
// Purpose: self-checking bench for the six-bit port
// Assumes: apb master with bounded waits, pins resolved by model
// Notes:   both other resets are run in one loop
`timescale 1ns/100ps
`default_nettype none
module sbp_port_tb;
  import sbp_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        master_clear_n_n  = 1'b1;
  logic        wd      = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [5:0]  ext     = 6'h2A;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, t0ck, ss_n, in_rst;
  logic [5:0]  lvl;
  sbp_pins_t   pins;
  int          bad_count   = 0;
  int          comparisons = 0;
  always #2 pclk = ~pclk;
  sbp_port i_dut (.pclk(pclk), .presetn(presetn), .master_clear_n(master_clear_n_n),
    .watchdog_reset(wd), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_i(lvl), .pins(pins),
    .timer0_external_clock_in(t0ck), .ssp_slave_select_n(ss_n), .in_reset(in_rst));
  sbp_ext_model i_ext (.ext_level(ext), .pins(pins), .pin_level(lvl));
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) begin
      bad_count++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, SBP_ADDR_DIR, 32'h0);
    chk(rd, 32'h3F);
    apb(1'b0, SBP_ADDR_DATA, 32'h0);
    chk(rd, 32'h2A);
    apb(1'b1, SBP_ADDR_DATA, 32'hFFFF_FFFF);
    apb(1'b1, SBP_ADDR_DIR, 32'h0);
    ext <= 6'h00;
    repeat (4) @(posedge pclk);
    chk({pins.o, pins.oe}, {6'h2F, 6'h2F});
    apb(1'b0, SBP_ADDR_DATA, 32'h0);
    chk(rd, 32'h2F);
    chk(t0ck, 1'b0);
    chk(ss_n, 1'b1);
    // master_clear_n first, then watchdog; latch must survive both
    for (int i = 0; i < 2; i++) begin
      if (i == 0) master_clear_n_n <= 1'b0;
      else wd <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(in_rst, 1'b1);
      master_clear_n_n <= 1'b1;
      wd     <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(pins.oe, 6'h00);
      apb(1'b1, SBP_ADDR_DIR, 32'h0);
      chk(er, 1'b0);
      chk(pready, 1'b1);
      repeat (2) @(posedge pclk);
      chk(pins.oe, 6'h2F);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
